//--- ipu_core.sv
// Interrupt priority unit: source masking, priority resolution, take/promote/halt, APB registers
// How it works
// - One interrupt at a time; simultaneous ones taken in fixed priority order.
// - One report per class; several data machine check types merge into one.
// - Masked exception stays as status and fires once unmasked unless cleared.
// - External enable gates the external input and both timer interrupts.
// - Machine check, alignment, storage and program cannot be masked: take or halt.
// - Machine check needs mcheck enable; other unmaskables need unmaskable enable.
// - Unmaskable with unmaskable enable 0 and mcheck enable 1 becomes machine check.
// - System reset is an unmaskable interrupt saving current address and state.
// - All asynchronous interrupts except system reset rank below all synchronous ones.
// - Debug and command halts stop at once, outranked only by system reset.
// - Reset from reset pin, or 01/10 written to either reset request field.
// - Data and instruction machine checks rank 2 and 3; halt without mcheck enable.
// - Instruction storage ranks 4; halts when both enables are 0.
// - Program ranks 5: illegal or trap; trap halts when trap select is 1.
// - Data storage 6 and alignment 7; data storage wins when both arise.
// - Watchdog needs enable and status; repeat event halts (11) or resets (01/10).
// - External input ranks 9; fixed interval timer ranks 10 with enable and status.
// - Async interrupt taken at boundary; saved address is next unexecuted instruction.
// - Address compare debug events halt before the address leaves the core.
// - Non-reset interrupts wait for imprecise checks; priority resolved after the wait.
// - Interrupted instruction commits nothing besides status and error data.
// - Handler address is prefix top bits joined with a 9-bit vector offset.
// - Taking clears external and unmaskable enables; machine check clears mcheck enable.
// - Unmaskable halt updates save, status and vector, halt cause 011.
// - Promotion clears mcheck first, sets mcheck source, saves as machine check.
`timescale 1ns/1ps
`default_nettype none
module ipu_core
   import ipu_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_irq_pin,
   input wire logic ext_reset_pin,
   input wire logic wdog_event,
   input wire logic fit_event,
   input wire ipu_fault_s fault,
   input wire logic [31:0] fault_pc,
   input wire logic [31:0] fault_addr,
   input wire logic [31:0] next_pc,
   input wire logic boundary,
   input wire logic mem_quiet,
   input wire logic rfi,
   output logic irq_take,
   output logic [31:0] irq_vector,
   output ipu_cause_e irq_cause,
   output logic core_halt,
   output logic reset_take,
   output logic commit_block
);
   ipu_state_e st_reg, st_next;
   ipu_mstate_s ms_reg, ms_next, srst_reg, srst_next;
   ipu_cause_e cause, cause_reg, cause_next;
   logic [3:0] tc_reg, tc_next;
   logic [1:0] ts_reg, ts_next;
   logic trap_sel_reg, trap_sel_next;
   logic [31:0] srpc_reg, srpc_next, edr_reg, edr_next, vpx_reg, vpx_next;
   logic [31:0] vec_reg, vec_next, prdata_reg, prdata_next;
   logic [7:0] isr_reg, isr_next;
   logic [2:0] hc_reg, hc_next;
   logic take_reg, take_next, halt_reg, halt_next, rtake_reg, rtake_next;
   logic cblk_reg, cblk_next, pready_reg, pslverr_reg, pslverr_next;
   logic ext_m, ext_s, rstp_m, rstp_s, rstp_d;
   logic wr, setup, mapped, sync_any, dbg_halt, async_pend, rst_req, cmd_halt;
   logic is_mc, is_unm, is_async, promote, halt_now;
   logic [8:0] voff;
   logic [31:0] rdv;

   // Pin inputs pass two flops; the reset pin has a third so logic reads the second and third for its rising edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ext_m <= 1'b0;
         ext_s <= 1'b0;
         rstp_m <= 1'b0;
         rstp_s <= 1'b0;
         rstp_d <= 1'b0;
      end else begin
         ext_m <= ext_irq_pin;
         ext_s <= ext_m;
         rstp_m <= ext_reset_pin;
         rstp_s <= rstp_m;
         rstp_d <= rstp_s;
      end
   end

   // Bus decode and read mux; zero wait states, unmapped answers with pslverr
   always_comb begin
      setup = psel & ~penable;
      wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;
      mapped = 1'b1;
      rdv = 32'h0000_0000;
      if (paddr == A_MSTATE) rdv = {28'h0000000, ms_reg};
      else if (paddr == A_TCTRL) rdv = {28'h0000000, tc_reg};
      else if (paddr == A_TSTAT) rdv = {30'h00000000, ts_reg};
      else if (paddr == A_DCTRL) rdv = {29'h00000000, trap_sel_reg, 2'h0};
      else if (paddr == A_XCTRL) rdv = 32'h0000_0000; // Command fields are write-only
      else if (paddr == A_SRPC) rdv = srpc_reg;
      else if (paddr == A_SRST) rdv = {28'h0000000, srst_reg};
      else if (paddr == A_ISTAT) rdv = {24'h000000, isr_reg};
      else if (paddr == A_EDATA) rdv = edr_reg;
      else if (paddr == A_XSTAT) rdv = {28'h0000000, halt_reg, hc_reg};
      else if (paddr == A_VPFX) rdv = {vpx_reg[31:VPFX_LSB], 9'h000};
      else mapped = 1'b0;
   end

   // Combinational priority selection over pending sources and enables
   always_comb begin
      sync_any = (|fault.dmc) | fault.imc | fault.isi | fault.illegal
         | (fault.trap & ~trap_sel_reg) | fault.dsi | fault.align;
      dbg_halt = fault.iac | fault.dac | (fault.trap & trap_sel_reg);
      async_pend = ms_reg.ee & (ext_s | (tc_reg[TC_WIE] & ts_reg[TS_WIS])
         | (tc_reg[TC_FIE] & ts_reg[TS_FIS]));
      cause = CS_NONE;
      if (|fault.dmc) cause = CS_DMC;
      else if (fault.imc) cause = CS_IMC;
      else if (fault.isi) cause = CS_ISI;
      else if (fault.illegal | (fault.trap & ~trap_sel_reg)) cause = CS_PROG;
      else if (fault.dsi) cause = CS_DSI;
      else if (fault.align) cause = CS_ALIGN;
      else if (ms_reg.ee & tc_reg[TC_WIE] & ts_reg[TS_WIS]) cause = CS_WDT;
      else if (ms_reg.ee & ext_s) cause = CS_EXT;
      else if (ms_reg.ee & tc_reg[TC_FIE] & ts_reg[TS_FIS]) cause = CS_FIT;
      is_mc = (cause == CS_DMC) | (cause == CS_IMC);
      is_unm = (cause == CS_ISI) | (cause == CS_PROG) | (cause == CS_DSI)
         | (cause == CS_ALIGN);
      is_async = (cause == CS_WDT) | (cause == CS_EXT) | (cause == CS_FIT);
      promote = is_unm & ~ms_reg.unmaskable_irq_enable & ms_reg.me;
      halt_now = (is_mc & ~ms_reg.me) | (is_unm & ~ms_reg.unmaskable_irq_enable & ~ms_reg.me);
      voff = V_MCHECK;
      case (cause)
         CS_ISI: voff = V_ISI;
         CS_PROG: voff = V_PROG;
         CS_DSI: voff = V_DSI;
         CS_ALIGN: voff = V_ALIGN;
         CS_WDT: voff = V_WDT;
         CS_EXT: voff = V_EXT;
         CS_FIT: voff = V_FIT;
         default: voff = V_MCHECK;
      endcase
      if (promote) voff = V_MCHECK;
   end

   // Next state of registers and sequencer
   always_comb begin
      st_next = st_reg;
      ms_next = ms_reg;
      srst_next = srst_reg;
      tc_next = tc_reg;
      ts_next = ts_reg;
      trap_sel_next = trap_sel_reg;
      srpc_next = srpc_reg;
      edr_next = edr_reg;
      vpx_next = vpx_reg;
      vec_next = vec_reg;
      isr_next = isr_reg;
      hc_next = hc_reg;
      cause_next = cause_reg;
      take_next = 1'b0;
      rtake_next = 1'b0;
      prdata_next = prdata_reg;
      pslverr_next = pslverr_reg;
      rst_req = rstp_s & ~rstp_d;
      cmd_halt = 1'b0;
      // Read data and error are captured in the setup cycle
      if (setup) begin
         prdata_next = rdv;
         pslverr_next = ~mapped;
      end
      // Software writes take effect at the access edge
      if (wr) begin
         if (paddr == A_MSTATE) ms_next = pwdata[3:0];
         else if (paddr == A_TCTRL) tc_next = pwdata[3:0];
         else if (paddr == A_TSTAT) ts_next = ts_reg & ~pwdata[1:0];
         else if (paddr == A_ISTAT) isr_next = isr_reg & ~pwdata[7:0];
         else if (paddr == A_SRPC) srpc_next = pwdata;
         else if (paddr == A_SRST) srst_next = pwdata[3:0];
         else if (paddr == A_EDATA) edr_next = pwdata;
         else if (paddr == A_VPFX) vpx_next = pwdata;
         else if (paddr == A_DCTRL) begin
            trap_sel_next = pwdata[DC_TRAP];
            if (^pwdata[DC_RST +: 2]) rst_req = 1'b1;
         end else if (paddr == A_XCTRL) begin
            if (^pwdata[XC_RST +: 2]) rst_req = 1'b1;
            cmd_halt = pwdata[XC_CMD +: 2] == CMD_HALT;
            if (pwdata[XC_CMD +: 2] == CMD_RESUME && st_reg == ST_HALT) begin
               st_next = ST_RUN;
               hc_next = HC_NONE;
            end
         end
      end
      // Timer events set status; a set in the clearing cycle wins
      if (fit_event) ts_next[TS_FIS] = 1'b1;
      if (wdog_event) ts_next[TS_WIS] = 1'b1;
      // Watchdog event while status is still set escalates
      if (wdog_event & ts_reg[TS_WIS]) begin
         if (tc_reg[TC_WRC +: 2] == WRC_HALT) begin
            st_next = ST_HALT;
            hc_next = HC_WDOG;
         end else if (^tc_reg[TC_WRC +: 2]) rst_req = 1'b1;
      end
      if (rfi & st_reg == ST_RUN) ms_next = srst_reg;
      if (rst_req) begin
         // System reset skips synchronization and outranks everything
         srpc_next = next_pc;
         srst_next = ms_reg;
         ms_next = MS_RST;
         vec_next = {vpx_reg[31:VPFX_LSB], V_RESET};
         cause_next = CS_RESET;
         rtake_next = 1'b1;
         hc_next = HC_NONE;
         st_next = ST_RUN;
      end else if (st_reg != ST_HALT && (dbg_halt | cmd_halt)) begin
         st_next = ST_HALT;
         hc_next = cmd_halt ? HC_CMD : HC_DEBUG;
      end else if (st_next != ST_HALT) begin
         case (st_reg)
            ST_RUN: begin
               if (sync_any | (boundary & async_pend)) st_next = ST_SYNC;
            end
            ST_SYNC: begin
               // Resolve only once earlier imprecise checks have landed
               if (mem_quiet && cause == CS_NONE) st_next = ST_RUN;
               else if (mem_quiet) begin
                  srpc_next = is_async ? next_pc : fault_pc;
                  srst_next = ms_reg;
                  ms_next.ee = 1'b0;
                  ms_next.unmaskable_irq_enable = 1'b0;
                  if (is_mc | promote) ms_next.me = 1'b0;
                  vec_next = {vpx_reg[31:VPFX_LSB], voff};
                  cause_next = cause;
                  if (is_mc) begin
                     isr_next[IS_MFE] = 1'b1;
                     isr_next[IS_MCS] = 1'b0;
                     isr_next[IS_DMC +: 3] = fault.dmc;
                     isr_next[IS_IMC] = cause == CS_IMC;
                  end
                  if (promote) begin
                     isr_next[IS_MFE] = 1'b0;
                     isr_next[IS_MCS] = 1'b1;
                  end
                  if (cause == CS_PROG) isr_next[IS_PTR] = fault.trap;
                  if (cause == CS_DSI || cause == CS_ALIGN) begin
                     isr_next[IS_ST] = fault.store;
                     edr_next = fault_addr;
                  end
                  if (cause == CS_DMC) edr_next = fault_addr;
                  if (halt_now) begin
                     st_next = ST_HALT;
                     hc_next = HC_UNMASK;
                  end else begin
                     st_next = ST_RUN;
                     take_next = 1'b1;
                  end
               end
            end
            default: st_next = st_reg;
         endcase
      end
      halt_next = st_next == ST_HALT;
      cblk_next = st_next != ST_RUN;
   end

   // State registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_reg <= ST_RUN;
         ms_reg <= MS_RST;
         srst_reg <= MS_RST;
         tc_reg <= 4'h0;
         ts_reg <= 2'h0;
         trap_sel_reg <= 1'b0;
         srpc_reg <= 32'h0000_0000;
         edr_reg <= 32'h0000_0000;
         vpx_reg <= VPFX_RST;
         vec_reg <= 32'h0000_0000;
         isr_reg <= 8'h00;
         hc_reg <= HC_NONE;
         cause_reg <= CS_NONE;
         take_reg <= 1'b0;
         rtake_reg <= 1'b0;
         halt_reg <= 1'b0;
         cblk_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ms_reg <= ms_next;
         srst_reg <= srst_next;
         tc_reg <= tc_next;
         ts_reg <= ts_next;
         trap_sel_reg <= trap_sel_next;
         srpc_reg <= srpc_next;
         edr_reg <= edr_next;
         vpx_reg <= vpx_next;
         vec_reg <= vec_next;
         isr_reg <= isr_next;
         hc_reg <= hc_next;
         cause_reg <= cause_next;
         take_reg <= take_next;
         rtake_reg <= rtake_next;
         halt_reg <= halt_next;
         cblk_reg <= cblk_next;
         prdata_reg <= prdata_next;
         pready_reg <= 1'b1;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq_take = take_reg;
   assign irq_vector = vec_reg;
   assign irq_cause = cause_reg;
   assign core_halt = halt_reg;
   assign reset_take = rtake_reg;
   assign commit_block = cblk_reg;

   // Checks on the resolver and the state it leaves behind
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic quiet_ok;
   assign quiet_ok = st_reg == ST_SYNC && mem_quiet && !rst_req && !dbg_halt && !cmd_halt
      && !(wdog_event & ts_reg[TS_WIS]);
   a_single_take: assert property (irq_take |=> !irq_take)
      else $error("two takes back to back");
   a_take_clears: assert property (irq_take |-> !ms_reg.ee && !ms_reg.unmaskable_irq_enable)
      else $error("take left enables set");
   a_mc_clears_me: assert property (quiet_ok && is_mc && ms_reg.me |=>
      irq_take && !ms_reg.me && vec_reg[8:0] == V_MCHECK)
      else $error("machine check did not clear enable");
   a_promote_path: assert property (quiet_ok && promote |=>
      irq_take && isr_reg[IS_MCS] && !isr_reg[IS_MFE] && vec_reg[8:0] == V_MCHECK)
      else $error("promotion not taken as machine check");
   a_unmask_halt: assert property (quiet_ok && halt_now |=>
      core_halt && hc_reg == HC_UNMASK && !irq_take)
      else $error("unmaskable halt mishandled");
   a_sync_wait: assert property (st_reg == ST_SYNC && !mem_quiet |=> !irq_take)
      else $error("take before synchronization");
   a_async_gated: assert property (irq_take && irq_cause inside {CS_WDT, CS_EXT, CS_FIT}
      |-> $past(ms_reg.ee) && srpc_reg == $past(next_pc))
      else $error("async take while masked or wrong pc");
   a_reset_save: assert property (rst_req |=> reset_take && srpc_reg == $past(next_pc)
      && vec_reg[8:0] == V_RESET)
      else $error("reset did not save context");
   a_debug_halt: assert property (st_reg == ST_RUN && fault.iac && !rst_req |=>
      core_halt ##0 !irq_take)
      else $error("address compare did not halt");
   a_dsi_first: assert property (quiet_ok && fault.dsi && fault.align && cause == CS_DSI
      && ms_reg.unmaskable_irq_enable |=> irq_vector[8:0] == V_DSI)
      else $error("alignment beat data storage");
   a_wis_sticky: assert property (wdog_event |=> ts_reg[TS_WIS])
      else $error("watchdog status lost");
   c_take_ext: cover property (irq_take && irq_cause == CS_EXT);
   c_promote: cover property (quiet_ok && promote);
   c_unmask_halt: cover property (quiet_ok && halt_now);
   c_reset: cover property (reset_take);
endmodule
`default_nettype wire

//--- ipu_pkg.sv
// Constants, types and register map of the interrupt priority unit
package ipu_pkg;
   // Machine state bits that the unit reads and updates
   typedef struct packed {
      logic imprecise_enable;
      logic unmaskable_irq_enable;
      logic me;
      logic ee;
   } ipu_mstate_s;
   // Synchronous faults reported by the pipeline for the current instruction
   typedef struct packed {
      logic [2:0] dmc;
      logic imc;
      logic isi;
      logic illegal;
      logic trap;
      logic dsi;
      logic align;
      logic store;
      logic iac;
      logic dac;
   } ipu_fault_s;
   typedef enum logic [3:0] {CS_NONE, CS_RESET, CS_DMC, CS_IMC, CS_ISI, CS_PROG,
      CS_DSI, CS_ALIGN, CS_WDT, CS_EXT, CS_FIT} ipu_cause_e;
   typedef enum logic [1:0] {ST_RUN, ST_SYNC, ST_HALT} ipu_state_e;
   // Register byte offsets
   localparam logic [11:0] A_MSTATE = 12'h000;
   localparam logic [11:0] A_TCTRL = 12'h004;
   localparam logic [11:0] A_TSTAT = 12'h008;
   localparam logic [11:0] A_DCTRL = 12'h00C;
   localparam logic [11:0] A_XCTRL = 12'h010;
   localparam logic [11:0] A_SRPC = 12'h014;
   localparam logic [11:0] A_SRST = 12'h018;
   localparam logic [11:0] A_ISTAT = 12'h01C;
   localparam logic [11:0] A_EDATA = 12'h020;
   localparam logic [11:0] A_XSTAT = 12'h024;
   localparam logic [11:0] A_VPFX = 12'h028;
   // Field positions
   localparam int TC_WIE = 0;
   localparam int TC_FIE = 1;
   localparam int TC_WRC = 2;
   localparam int TS_WIS = 0;
   localparam int TS_FIS = 1;
   localparam int DC_RST = 0;
   localparam int DC_TRAP = 2;
   localparam int XC_RST = 0;
   localparam int XC_CMD = 2;
   localparam int IS_MCS = 0;
   localparam int IS_MFE = 1;
   localparam int IS_PTR = 2;
   localparam int IS_ST = 3;
   localparam int IS_DMC = 4;
   localparam int IS_IMC = 7;
   localparam int VPFX_LSB = 9;
   // Field codes
   localparam logic [1:0] WRC_HALT = 2'h3;
   localparam logic [1:0] CMD_HALT = 2'h1;
   localparam logic [1:0] CMD_RESUME = 2'h2;
   localparam logic [2:0] HC_NONE = 3'h0;
   localparam logic [2:0] HC_DEBUG = 3'h1;
   localparam logic [2:0] HC_CMD = 3'h2;
   localparam logic [2:0] HC_UNMASK = 3'h3;
   localparam logic [2:0] HC_WDOG = 3'h4;
   // Vector offsets, multiples of 32 bytes
   localparam logic [8:0] V_MCHECK = 9'h000;
   localparam logic [8:0] V_RESET = 9'h040;
   localparam logic [8:0] V_DSI = 9'h060;
   localparam logic [8:0] V_ISI = 9'h080;
   localparam logic [8:0] V_EXT = 9'h0A0;
   localparam logic [8:0] V_ALIGN = 9'h0C0;
   localparam logic [8:0] V_PROG = 9'h0E0;
   localparam logic [8:0] V_FIT = 9'h120;
   localparam logic [8:0] V_WDT = 9'h140;
   // Values after reset
   localparam ipu_mstate_s MS_RST = 4'h0;
   localparam logic [31:0] VPFX_RST = 32'h0000_0000;
endpackage

//--- ipu_pipe_model.sv
// Pipeline stand-in: boundary and memory quiet handshake
`timescale 1ns/1ps
`default_nettype none
module ipu_pipe_model
   import ipu_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic commit_block,
   output logic mem_quiet,
   output logic boundary
);
   logic [1:0] wait_reg;
   logic [1:0] wait_next;
   // Slow mode holds back quiet for three cycles of sync, as late stores would
   always_comb begin
      wait_next = wait_reg;
      if (!commit_block) begin
         wait_next = 2'h0;
      end else if (wait_reg != 2'h3) begin
         wait_next = wait_reg + 2'h1;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wait_reg <= 2'h0;
      end else begin
         wait_reg <= wait_next;
      end
   end
   assign mem_quiet = commit_block && (!slow || wait_reg == 2'h3);
   assign boundary = 1'b1; // Every cycle is an instruction boundary
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the interrupt priority unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ipu_pkg::*;
   localparam logic [31:0] PF = 32'hABCD_E200;
   localparam logic [31:0] FPC = 32'h0000_1230;
   localparam logic [31:0] NPC = 32'h0000_4560;
   typedef struct packed {
      logic [3:0] ms;
      logic [11:0] f;
      logic h;
      ipu_cause_e c;
      logic [8:0] v;
      logic [3:0] mo;
      logic [3:0] xs;
   } ipu_row_s;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, ext_irq_pin = 0, fit_event = 0, irq_take, core_halt, reset_take;
   logic commit_block, mem_quiet, boundary;
   ipu_fault_s fault = '0;
   logic [31:0] irq_vector;
   ipu_cause_e irq_cause;
   int n_fail = 0, checks_done = 0, i, k;
   ipu_row_s rows[12] = '{
      '{4'h4, 12'h010, 0, CS_DSI, V_DSI, 4'h0, 4'h0}, '{4'h4, 12'h018, 0, CS_DSI, V_DSI, 4'h0, 4'h0},
      '{4'h4, 12'h008, 0, CS_ALIGN, V_ALIGN, 4'h0, 4'h0}, '{4'h4, 12'h040, 0, CS_PROG, V_PROG, 4'h0, 4'h0},
      '{4'h4, 12'h080, 0, CS_ISI, V_ISI, 4'h0, 4'h0}, '{4'h2, 12'h100, 0, CS_IMC, V_MCHECK, 4'h0, 4'h0},
      '{4'h2, 12'h600, 0, CS_DMC, V_MCHECK, 4'h0, 4'h0}, '{4'h2, 12'h010, 0, CS_DSI, V_MCHECK, 4'h0, 4'h0},
      '{4'h6, 12'h180, 0, CS_IMC, V_MCHECK, 4'h0, 4'h0}, '{4'h0, 12'h080, 1, CS_ISI, V_ISI, 4'h0, 4'hB},
      '{4'h0, 12'h002, 1, CS_NONE, 9'h000, 4'h0, 4'h9}, '{4'hB, 12'h010, 0, CS_DSI, V_MCHECK, 4'h8, 4'h0}};
   always #25 clock = ~clock;
   ipu_core i_ipu_core (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .ext_reset_pin(1'b0), .wdog_event(1'b0),
      .fit_event(fit_event), .fault(fault), .fault_pc(FPC), .fault_addr(32'h0000_0100),
      .next_pc(NPC), .boundary(boundary), .mem_quiet(mem_quiet), .rfi(1'b0),
      .irq_take(irq_take), .irq_vector(irq_vector), .irq_cause(irq_cause),
      .core_halt(core_halt), .reset_take(reset_take), .commit_block(commit_block));
   ipu_pipe_model i_ipu_pipe_model (.clock(clock), .rst_n(rst_n), .slow(slow),
      .commit_block(commit_block), .mem_quiet(mem_quiet), .boundary(boundary));
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int j;
      @(posedge clock);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      for (j = 0; j < 20; j++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      q = pslverr ? 32'hEEEE_EEEE : prdata;
      psel <= 0; penable <= 0;
      if (j == 20) begin n_fail++; conclude(); end
   endtask
   task automatic rst();
      rst_n <= 0; fault <= '0; ext_irq_pin <= 0;
      repeat (2) @(posedge clock);
      rst_n <= 1;
      apb(1, A_VPFX, PF);
   endtask
   // Wait, bounded, for a take, a halt or a reset entry
   task automatic wt();
      for (k = 0; k < 60; k++) begin
         @(posedge clock);
         if (irq_take === 1'b1 || core_halt === 1'b1 || reset_take === 1'b1) break;
      end
      fault <= '0; ext_irq_pin <= 0;
      if (k == 60) begin n_fail++; conclude(); end
   endtask
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1;
      @(posedge clock);
      chk({irq_take, core_halt, commit_block}, 0);
      apb(0, A_MSTATE, 0); chk(q, MS_RST);
      apb(0, 12'hFF0, 0); chk(q, 32'hEEEE_EEEE); // Unmapped address
      // Table of synchronous cases, alternating prompt and slow sync
      for (i = 0; i < 12; i++) begin
         rst(); apb(1, A_MSTATE, rows[i].ms); slow <= i[0];
         fault <= ipu_fault_s'(rows[i].f);
         wt();
         chk(core_halt, rows[i].h);
         if (rows[i].xs != 4'h9) chk(irq_vector, PF | rows[i].v);
         if (rows[i].h) begin
            apb(0, A_XSTAT, 0); chk(q, rows[i].xs);
         end else begin
            chk(irq_cause, rows[i].c);
            apb(0, A_MSTATE, 0); chk(q, rows[i].mo);
            apb(0, A_SRPC, 0); chk(q, FPC);
            apb(0, A_ISTAT, 0);
            // Source status marks promotions only, never a genuine machine check
            chk(q[IS_MCS], rows[i].v == V_MCHECK && !(rows[i].c inside {CS_DMC, CS_IMC}));
         end
      end
      // Masked external input persists, then fires once enabled
      rst(); apb(1, A_MSTATE, 0); ext_irq_pin <= 1; // Held until serviced
      k = 0;
      repeat (10) begin @(posedge clock); if (irq_take) k++; end
      chk(k, 0);
      apb(1, A_MSTATE, 1); wt(); chk(irq_cause, CS_EXT);
      apb(0, A_SRPC, 0); chk(q, NPC);
      // Async source loses to a synchronous fault
      rst(); apb(1, A_MSTATE, 5); ext_irq_pin <= 1; fault <= ipu_fault_s'(12'h010);
      wt(); chk(irq_cause, CS_DSI);
      // Fixed interval timer with its enable and status
      rst(); apb(1, A_TCTRL, 2);
      @(posedge clock); fit_event <= 1;
      @(posedge clock); fit_event <= 0;
      apb(1, A_MSTATE, 1); wt(); chk(irq_cause, CS_FIT);
      // Reset requests through both control registers, both codes
      for (i = 0; i < 4; i++) begin
         rst(); apb(1, i[1] ? A_XCTRL : A_DCTRL, i[0] ? 1 : 2);
         wt(); chk(reset_take, 1);
         chk(irq_vector, PF | V_RESET);
         apb(0, A_SRPC, 0); chk(q, NPC);
      end
      // Trap with trap select set halts instead of interrupting
      rst(); apb(1, A_DCTRL, 4); apb(1, A_MSTATE, 4); fault <= ipu_fault_s'(12'h020);
      wt(); chk(core_halt, 1);
      apb(0, A_XSTAT, 0); chk(q, 4'h9);
      conclude();
   end
endmodule
`default_nettype wire
